// ==== rtl/oscsel_top.sv ====
// Oscillator control: register file, source selection, glitch-free switch-over and sleep mode
module oscsel_top
  import oscsel_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic SLEEP_REQ,
  input wire logic TWO_SPEED_STARTUP_CONFIG,
  input wire logic [3:0] PRIMARY_OSC_CONFIG,
  input wire logic PRIMARY_READY,
  input wire logic SECONDARY_READY,
  input wire logic HF_READY,
  input wire logic MF_READY,
  input wire logic LF_READY,
  output logic [2:0] CLOCK_SOURCE,
  output logic [3:0] DIVIDE_LOG2,
  output logic [3:0] PRIMARY_MODE,
  output logic SWITCH_BUSY,
  output logic IDLE_MODE,
  output logic SLEEP_MODE,
  output logic IRQ
);
  import oscsel_pkg::*;

  logic rst_meta;
  logic rst_sync_n;
  logic [4:0] rdy_m;
  logic [4:0] rdy;
  logic idle_on_sleep_select;
  logic [2:0] internal_freq_select;
  logic [1:0] system_clock_select;
  logic low_freq_source_select;
  logic mid_freq_select;
  logic [5:0] tuning_rest;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic startup_timeout_status;
  logic strap_taken;
  logic hf_prev;
  logic [2:0] next_source;
  logic [3:0] next_divide;
  logic [2:0] cur_source;
  logic [3:0] cur_divide;
  logic [2:0] pend_source;
  logic [3:0] pend_divide;
  oscsel_state_t state;
  logic [16:0] wait_cnt;
  logic [2:0] irq_set;
  logic [7:0] next_rdata;
  logic [7:0] control_view;

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Ready levels come from analog oscillators, so two flops each
  always_ff @(posedge CLK_SYS or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rdy_m <= 5'h00;
      rdy <= 5'h00;
    end
    else
    begin
      rdy_m <= {LF_READY, MF_READY, HF_READY, SECONDARY_READY, PRIMARY_READY};
      rdy <= rdy_m;
    end
  end

  // Requested source and divider from the control fields
  always_comb
  begin
    next_source = SRC_HF;
    next_divide = 4'h7 - {1'b0, internal_freq_select};
    if (system_clock_select == CLKSEL_PRIMARY)
    begin
      next_source = SRC_PRIMARY;
      next_divide = 4'h0;
    end
    else if (system_clock_select == CLKSEL_SECONDARY)
    begin
      next_source = SRC_SECONDARY;
      next_divide = 4'h0;
    end
    else if (internal_freq_select == FREQ_LOWEST)
    begin
      if (!low_freq_source_select)
      begin
        next_source = SRC_LF;
        next_divide = 4'h0;
      end
      else if (!mid_freq_select)
      begin
        next_source = SRC_HF;
        next_divide = DIV_HF_LOWEST;
      end
      else
      begin
        next_source = SRC_MF;
        next_divide = DIV_MF_000;
      end
    end
    else if (internal_freq_select == FREQ_DIV32 || internal_freq_select == FREQ_DIV64)
    begin
      if (mid_freq_select)
      begin
        next_source = SRC_MF;
        next_divide = (internal_freq_select == FREQ_DIV32) ? 4'h0 : DIV_MF_001;
      end
      else
      begin
        next_source = SRC_HF;
        next_divide = (internal_freq_select == FREQ_DIV32) ? 4'h5 : 4'h6;
      end
    end
  end

  // Register writes
  always_ff @(posedge CLK_SYS or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      idle_on_sleep_select <= 1'b0;
      internal_freq_select <= FREQ_RESET;
      system_clock_select <= CLKSEL_PRIMARY;
      low_freq_source_select <= 1'b0;
      tuning_rest <= 6'h00;
      mid_freq_select <= 1'b0;
      irq_mask <= 3'h0;
    end
    else if (WR)
    begin
      case (ADDR)
        ADDR_CONTROL:
        begin
          idle_on_sleep_select <= WDATA[BIT_IDLE];
          internal_freq_select <= WDATA[BIT_FREQ_HI:BIT_FREQ_LO];
          system_clock_select <= WDATA[BIT_CLKSEL_HI:BIT_CLKSEL_LO];
        end
        ADDR_TUNING:
        begin
          low_freq_source_select <= WDATA[BIT_SRC_SEL];
          tuning_rest <= WDATA[5:0];
        end
        ADDR_CONTROL_TWO: mid_freq_select <= WDATA[BIT_MID_SEL];
        ADDR_IRQ_MASK: irq_mask <= WDATA[IRQ_BITS-1:0];
        default: ;
      endcase
    end
  end

  // Glitch-free switch: old source keeps running until the new one reports ready
  always_ff @(posedge CLK_SYS or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state <= OSCSEL_WAIT;
      cur_source <= SRC_HF;
      cur_divide <= 4'h4;
      pend_source <= SRC_PRIMARY;
      pend_divide <= 4'h0;
      wait_cnt <= 17'h00000;
    end
    else
    begin
      case (state)
        OSCSEL_RUN:
        begin
          if (next_source != cur_source || next_divide != cur_divide)
          begin
            pend_source <= next_source;
            pend_divide <= next_divide;
            wait_cnt <= 17'h00000;
            state <= OSCSEL_WAIT;
          end
        end
        OSCSEL_WAIT:
        begin
          // A request that changes mid-wait restarts the wait on the new target
          if (next_source != pend_source || next_divide != pend_divide)
          begin
            pend_source <= next_source;
            pend_divide <= next_divide;
            wait_cnt <= 17'h00000;
          end
          else if (rdy[pend_source])
            state <= OSCSEL_SWAP;
          else if (wait_cnt == 17'(SWITCH_TIMEOUT_CYC - 1))
            state <= OSCSEL_RUN; // Never-ready source: stay on the old one
          else
            wait_cnt <= wait_cnt + 17'h00001;
        end
        OSCSEL_SWAP:
        begin
          cur_source <= pend_source;
          cur_divide <= pend_divide;
          state <= OSCSEL_RUN;
        end
        default: state <= OSCSEL_RUN;
      endcase
    end
  end

  // Two-speed start-up strap caught after reset release
  always_ff @(posedge CLK_SYS or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      strap_taken <= 1'b0;
      startup_timeout_status <= 1'b0;
    end
    else if (!strap_taken)
    begin
      strap_taken <= 1'b1;
      startup_timeout_status <= !TWO_SPEED_STARTUP_CONFIG;
    end
    else
      startup_timeout_status <= (cur_source == SRC_PRIMARY);
  end

  assign irq_set[IRQ_SWITCH] = (state == OSCSEL_SWAP);
  assign irq_set[IRQ_HF_UP] = rdy[SRC_HF] && !hf_prev;
  assign irq_set[IRQ_HF_DOWN] = !rdy[SRC_HF] && hf_prev;

  // Read clears status, but an event in the same cycle wins
  always_ff @(posedge CLK_SYS or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      hf_prev <= 1'b0;
      irq_status <= 3'h0;
    end
    else
    begin
      hf_prev <= rdy[SRC_HF];
      if (RD && ADDR == ADDR_IRQ_STATUS)
        irq_status <= irq_set;
      else
        irq_status <= irq_status | irq_set;
    end
  end

  assign control_view = {idle_on_sleep_select, internal_freq_select, startup_timeout_status,
                         rdy[SRC_HF], system_clock_select};

  always_comb
  begin
    case (ADDR)
      ADDR_CONTROL: next_rdata = control_view;
      ADDR_TUNING: next_rdata = {low_freq_source_select, 1'b0, tuning_rest};
      ADDR_CONTROL_TWO: next_rdata = {3'h0, mid_freq_select, 1'b0, rdy[SRC_HF], rdy[SRC_MF], rdy[SRC_LF]};
      ADDR_IRQ_STATUS: next_rdata = {5'h00, irq_status};
      ADDR_IRQ_MASK: next_rdata = {5'h00, irq_mask};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      RDATA <= 8'h00;
    else if (RD)
      RDATA <= next_rdata;
    else
      RDATA <= 8'h00;
  end

  // Sleep requests are one-cycle pulses; a mode stays until the next request, which sets idle or sleep again from the idle-on-sleep bit
  always_ff @(posedge CLK_SYS or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      IDLE_MODE <= 1'b0;
      SLEEP_MODE <= 1'b0;
    end
    else if (SLEEP_REQ)
    begin
      IDLE_MODE <= idle_on_sleep_select;
      SLEEP_MODE <= !idle_on_sleep_select;
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      CLOCK_SOURCE <= SRC_HF;
      DIVIDE_LOG2 <= 4'h4;
      PRIMARY_MODE <= 4'h0;
      SWITCH_BUSY <= 1'b1;
      IRQ <= 1'b0;
    end
    else
    begin
      CLOCK_SOURCE <= cur_source;
      DIVIDE_LOG2 <= cur_divide;
      PRIMARY_MODE <= PRIMARY_OSC_CONFIG;
      SWITCH_BUSY <= (state != OSCSEL_RUN);
      IRQ <= |(irq_status & irq_mask);
    end
  end
endmodule // oscsel_top

// ==== rtl/oscsel_pkg.sv ====
// Package with register layout, reset values and timing counts for the oscillator select block
// How it works
// - With the idle-on-sleep bit set a sleep request enters idle mode, otherwise it enters full sleep.
// - Frequency codes 111 and 110 give the high-frequency internal oscillator undivided (16 MHz) and halved (8 MHz).
// - With mid-frequency select clear, codes 010 and 001 divide the high-frequency oscillator by 32 and 64.
// - Code 000 with low-frequency source select clear picks the low-frequency oscillator, stable on its flag.
// - Code 000 with source select set and mid select clear derives the clock from the high-frequency oscillator.
// - Code 000 with source select and mid select both set derives the clock from the mid-frequency oscillator.
// - Codes 010 and 001 use the high-frequency oscillator when mid select is clear, whatever the source select.
// - Codes 010 and 001 use the mid-frequency oscillator when mid select is set, whatever the source select.
// - Codes 011 to 111 always use the high-frequency oscillator.
// - The frequency field resets to 011, the high-frequency oscillator divided by 16.
// - Source choice also depends on a source select bit in the tuning register and a mid select bit in control two.
// - The start-up timeout status reads 1 while running from the primary clock and 0 on an internal oscillator.
// - The start-up timeout status resets to 0 and holds the inverse of the two-speed start-up configuration for one cycle after reset.
// - The high-frequency stable flag reads 1 exactly when that oscillator is stable.
// - Clock select 1x picks the internal oscillator block and 01 the secondary oscillator.
// - Clock select 00 picks the primary clock whose kind is set by the primary oscillator configuration.
package oscsel_pkg;
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_TUNING = 4'h1;
  localparam logic [3:0] ADDR_CONTROL_TWO = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
  localparam int BIT_IDLE = 7;
  localparam int BIT_FREQ_HI = 6;
  localparam int BIT_FREQ_LO = 4;
  localparam int BIT_STARTUP = 3;
  localparam int BIT_HF_STABLE = 2;
  localparam int BIT_CLKSEL_HI = 1;
  localparam int BIT_CLKSEL_LO = 0;
  localparam int BIT_SRC_SEL = 7;
  localparam int BIT_MID_SEL = 4;
  localparam int BIT_MF_STABLE = 1;
  localparam int BIT_LF_STABLE = 0;
  localparam logic [2:0] FREQ_RESET = 3'h3;
  localparam logic [2:0] FREQ_DIV1 = 3'h7;
  localparam logic [2:0] FREQ_DIV2 = 3'h6;
  localparam logic [2:0] FREQ_DIV32 = 3'h2;
  localparam logic [2:0] FREQ_DIV64 = 3'h1;
  localparam logic [2:0] FREQ_LOWEST = 3'h0;
  localparam logic [1:0] CLKSEL_PRIMARY = 2'h0;
  localparam logic [1:0] CLKSEL_SECONDARY = 2'h1;
  // Interrupt status bits: switch done, high-frequency stable gained, lost
  localparam int IRQ_SWITCH = 0;
  localparam int IRQ_HF_UP = 1;
  localparam int IRQ_HF_DOWN = 2;
  localparam int IRQ_BITS = 3;
  // Source codes
  localparam logic [2:0] SRC_PRIMARY = 3'h0;
  localparam logic [2:0] SRC_SECONDARY = 3'h1;
  localparam logic [2:0] SRC_HF = 3'h2;
  localparam logic [2:0] SRC_MF = 3'h3;
  localparam logic [2:0] SRC_LF = 3'h4;
  // HF divider exponent for frequency code 000, and MF divider exponents
  localparam logic [3:0] DIV_HF_LOWEST = 4'h9;
  localparam logic [3:0] DIV_MF_001 = 4'h1;
  localparam logic [3:0] DIV_MF_000 = 4'h4;
  // Switch-over wait: time in ns before giving up on a new source
  localparam int SWITCH_TIMEOUT_NS = 100000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SWITCH_TIMEOUT_CYC = SWITCH_TIMEOUT_NS / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    OSCSEL_RUN = 3'b001,
    OSCSEL_WAIT = 3'b010,
    OSCSEL_SWAP = 3'b100
  } oscsel_state_t;
endpackage

// ==== sim/oscsel_checker.sv ====
// Port-level assertions for the oscillator select block
module oscsel_checker
  import oscsel_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic RD,
  input wire logic WR,
  input wire logic [7:0] RDATA,
  input wire logic SLEEP_REQ,
  input wire logic [3:0] PRIMARY_OSC_CONFIG,
  input wire logic [2:0] CLOCK_SOURCE,
  input wire logic [3:0] DIVIDE_LOG2,
  input wire logic [3:0] PRIMARY_MODE,
  input wire logic SWITCH_BUSY,
  input wire logic IDLE_MODE,
  input wire logic SLEEP_MODE
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] up;
  logic [10:0] busy_cnt;
  // The internal reset copy lags the pin, so checks wait a few edges
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      up <= 3'h0;
    else if (up != 3'h7)
      up <= up + 3'h1;
  end
  // Any write may retarget a switch in progress, so the busy span is counted from the last write
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      busy_cnt <= 11'h000;
    else if (!SWITCH_BUSY || WR)
      busy_cnt <= 11'h000;
    else if (busy_cnt != 11'h7FF)
      busy_cnt <= busy_cnt + 11'h001;
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N || up < 3'h5);
  property p_sleep_mode; SLEEP_REQ |=> IDLE_MODE ^ SLEEP_MODE; endproperty
  a_sleep_mode: assert property (p_sleep_mode) else $error("no single sleep mode");
  property p_mode_hold; !SLEEP_REQ |=> $stable(IDLE_MODE) && $stable(SLEEP_MODE); endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("sleep mode moved");
  property p_read_idle; !RD |=> RDATA == 8'h00; endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data without read");
  property p_hf_div; CLOCK_SOURCE == SRC_HF |-> DIVIDE_LOG2 inside {[4'h0:4'h7], 4'h9}; endproperty
  a_hf_div: assert property (p_hf_div) else $error("bad fast divide");
  property p_mf_div; CLOCK_SOURCE == SRC_MF |-> DIVIDE_LOG2 inside {4'h0, 4'h1, 4'h4}; endproperty
  a_mf_div: assert property (p_mf_div) else $error("bad mid divide");
  property p_lf_div; CLOCK_SOURCE == SRC_LF |-> DIVIDE_LOG2 == 4'h0; endproperty
  a_lf_div: assert property (p_lf_div) else $error("slow source divided");
  property p_sw_gated; $changed(CLOCK_SOURCE) |-> $past(SWITCH_BUSY) || $past(SWITCH_BUSY, 2); endproperty
  a_sw_gated: assert property (p_sw_gated) else $error("source changed outside switch");
  property p_busy_bound; busy_cnt < 11'h3F2; endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("switch never ended");
  property p_prim_copy;
    $stable(PRIMARY_OSC_CONFIG) ##1 $stable(PRIMARY_OSC_CONFIG) |-> PRIMARY_MODE == PRIMARY_OSC_CONFIG;
  endproperty
  a_prim_copy: assert property (p_prim_copy) else $error("primary mode not copied");
endmodule // oscsel_checker

// ==== sim/oscillator_control_select_tb.sv ====
// Self-checking bench for the oscillator select block
module oscillator_control_select_tb
  import oscsel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic SLEEP_REQ = 1'b0;
  logic TWO_SPD = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00;
  // Ready levels: primary, secondary, fast, mid, slow
  logic [4:0] RDY = 5'h1F;
  logic [3:0] POSC = 4'hA;
  logic [7:0] RDATA, got;
  logic [2:0] CLOCK_SOURCE;
  logic [3:0] DIVIDE_LOG2, PRIMARY_MODE;
  logic SWITCH_BUSY, IDLE_MODE, SLEEP_MODE, IRQ;
  int n_mismatch = 0;
  int checked = 0;
  // freq, source select, mid select, expected source, expected divide
  logic [11:0] tbl [10] = '{{3'h7, 2'h0, SRC_HF, 4'h0}, {3'h6, 2'h3, SRC_HF, 4'h1}, {3'h3, 2'h1, SRC_HF, 4'h4},
    {3'h2, 2'h0, SRC_HF, 4'h5}, {3'h1, 2'h2, SRC_HF, 4'h6}, {3'h2, 2'h3, SRC_MF, 4'h0}, {3'h1, 2'h1, SRC_MF, 4'h1},
    {3'h0, 2'h0, SRC_LF, 4'h0}, {3'h0, 2'h2, SRC_HF, 4'h9}, {3'h0, 2'h3, SRC_MF, 4'h4}};
  always #50 CLK_SYS = ~CLK_SYS;
  oscsel_top i_dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .SLEEP_REQ(SLEEP_REQ), .TWO_SPEED_STARTUP_CONFIG(TWO_SPD), .PRIMARY_OSC_CONFIG(POSC), .PRIMARY_READY(RDY[4]),
    .SECONDARY_READY(RDY[3]), .HF_READY(RDY[2]), .MF_READY(RDY[1]), .LF_READY(RDY[0]), .CLOCK_SOURCE(CLOCK_SOURCE),
    .DIVIDE_LOG2(DIVIDE_LOG2), .PRIMARY_MODE(PRIMARY_MODE), .SWITCH_BUSY(SWITCH_BUSY), .IDLE_MODE(IDLE_MODE),
    .SLEEP_MODE(SLEEP_MODE), .IRQ(IRQ));
  task automatic conclude;
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1 got = RDATA;
  endtask
  // Bounded wait so a stuck switch cannot hang the run
  task automatic settle;
    int n;
    repeat (4) @(negedge CLK_SYS);
    for (n = 0; n < 1200 && SWITCH_BUSY !== 1'b0; n++)
      @(negedge CLK_SYS);
  endtask
  task automatic do_reset(input logic two);
    @(posedge CLK_SYS);
    RST_N <= 1'b0;
    TWO_SPD <= two;
    repeat (4) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    repeat (5) @(posedge CLK_SYS);
  endtask
  task automatic sleep_pulse;
    @(posedge CLK_SYS);
    SLEEP_REQ <= 1'b1;
    @(posedge CLK_SYS);
    SLEEP_REQ <= 1'b0;
    repeat (2) @(negedge CLK_SYS);
  endtask
  initial
  begin
    logic [2:0] f, src;
    logic [1:0] sm;
    logic [3:0] dv;
    do_reset(1'b0);
    settle();
    rd(ADDR_CONTROL);
    check("control", got, 8'h3C);
    check("source", {5'h00, CLOCK_SOURCE}, {5'h00, SRC_PRIMARY});
    check("mode", {4'h0, PRIMARY_MODE}, 8'h0A);
    wr(ADDR_CONTROL, 8'h31);
    settle();
    rd(ADDR_CONTROL);
    check("control", got, 8'h35);
    check("source", {5'h00, CLOCK_SOURCE}, {5'h00, SRC_SECONDARY});
    foreach (tbl[i])
    begin
      {f, sm, src, dv} = tbl[i];
      wr(ADDR_TUNING, {sm[1], 7'h00});
      wr(ADDR_CONTROL_TWO, {3'h0, sm[0], 4'h0});
      wr(ADDR_CONTROL, {1'b0, f, 4'h2});
      settle();
      check("source", {5'h00, CLOCK_SOURCE}, {5'h00, src});
      check("divide", {4'h0, DIVIDE_LOG2}, {4'h0, dv});
    end
    wr(4'hF, 8'hFF);
    rd(4'hF);
    check("unmapped", got, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h04);
    rd(ADDR_IRQ_STATUS);
    @(posedge CLK_SYS);
    RDY <= 5'h1B;
    repeat (5) @(negedge CLK_SYS);
    check("irq", {7'h00, IRQ}, 8'h01);
    rd(ADDR_CONTROL);
    check("control", got, 8'h02);
    rd(ADDR_IRQ_STATUS);
    check("status", got, 8'h04);
    // The clear lands with the read strobe, the level output follows one edge later
    repeat (2) @(negedge CLK_SYS);
    check("irq", {7'h00, IRQ}, 8'h00);
    rd(ADDR_CONTROL_TWO);
    check("control two", got, 8'h13);
    wr(ADDR_CONTROL, 8'h72);
    repeat (500) @(negedge CLK_SYS);
    check("busy", {7'h00, SWITCH_BUSY}, 8'h01);
    check("source", {5'h00, CLOCK_SOURCE}, {5'h00, SRC_MF});
    @(posedge CLK_SYS);
    RDY <= 5'h1F;
    settle();
    check("source", {5'h00, CLOCK_SOURCE}, {5'h00, SRC_HF});
    check("irq", {7'h00, IRQ}, 8'h00);
    wr(ADDR_CONTROL, 8'hF2);
    sleep_pulse();
    check("idle", {6'h00, IDLE_MODE, SLEEP_MODE}, 8'h02);
    wr(ADDR_CONTROL, 8'h72);
    sleep_pulse();
    check("sleep", {6'h00, IDLE_MODE, SLEEP_MODE}, 8'h01);
    @(posedge CLK_SYS);
    POSC <= 4'h5;
    RDY <= 5'h0F;
    repeat (2) @(negedge CLK_SYS);
    check("mode", {4'h0, PRIMARY_MODE}, 8'h05);
    do_reset(1'b1);
    rd(ADDR_CONTROL);
    check("control", got, 8'h34);
    check("source", {5'h00, CLOCK_SOURCE}, {5'h00, SRC_HF});
    conclude();
  end
  initial
  begin
    #(30000 * 100);
    n_mismatch++;
    conclude();
  end
endmodule // oscillator_control_select_tb
bind oscsel_top oscsel_checker i_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .RD(RD), .WR(WR), .RDATA(RDATA),
  .SLEEP_REQ(SLEEP_REQ), .PRIMARY_OSC_CONFIG(PRIMARY_OSC_CONFIG), .CLOCK_SOURCE(CLOCK_SOURCE),
  .DIVIDE_LOG2(DIVIDE_LOG2), .PRIMARY_MODE(PRIMARY_MODE), .SWITCH_BUSY(SWITCH_BUSY), .IDLE_MODE(IDLE_MODE),
  .SLEEP_MODE(SLEEP_MODE));
